// ### sffc_slot_fifo_cfg.sv
// Summary of operation
// - first slot enable bit 0 starts slot
// - second slot enable bit 5 starts slot
// - first slot format bits 4:2 choose data
// - second slot format bits 8:6, same codes
// - code 1 sum16, code 2 sum32
// - code 4 four ch16, code 6 four ch32
// - second slot stores if averaging matches or first format is code 0
// - guard off wraps, guard on drops
`default_nettype none
module sffc_slot_fifo_cfg (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire sffc_pkg::sffc_apb_req_t apb_req,
  output sffc_pkg::sffc_apb_resp_t     apb_resp,
  input  wire logic                    period_valid,
  output logic                         period_ready,
  input  wire sffc_pkg::sffc_period_t  period_data,
  output logic                         first_slot_active,
  output logic                         second_slot_active
);
  import sffc_pkg::*;

  typedef struct packed {
    sffc_state_t       state;
    logic [2:0]        idx;
    sffc_slot_cfg_t    cfg;
    logic [15:0]       avg;
    logic [15:0]       sync_word;
    logic [1:0]        sync_sel;
    logic [31:0]       prdata;
    logic [7:0]        dropped;
    sffc_slot_sample_t a_data;
    sffc_slot_sample_t b_data;
    logic [2:0]        a_fmt;
    logic [2:0]        b_fmt;
    logic              b_go;
    logic              guard;
  } sffc_core_state_t;

  localparam sffc_core_state_t CORE_RST = '{
    state: ST_IDLE, idx: 3'h0, cfg: SLOT_CFG_RST, avg: AVG_CFG_RST, sync_word: SYNC_WORD_RST,
    sync_sel: SYNC_SEL_RST, prdata: 32'h0000_0000, dropped: 8'h00, a_data: '0, b_data: '0,
    a_fmt: FMT_NONE, b_fmt: FMT_NONE, b_go: 1'b0, guard: 1'b1};

  function automatic logic addr_hit(input logic [11:0] a);
    if (a == ADDR_SLOT_CFG) begin
      addr_hit = 1'b1;
    end else if (a == ADDR_AVG_CFG) begin
      addr_hit = 1'b1;
    end else if (a == ADDR_SYNC_WORD) begin
      addr_hit = 1'b1;
    end else if (a == ADDR_SYNC_SEL) begin
      addr_hit = 1'b1;
    end else if (a == ADDR_STATUS) begin
      addr_hit = 1'b1;
    end else if (a == ADDR_FIFO_DATA) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  endfunction

  sffc_core_state_t      r_reg;
  sffc_core_state_t      r_next;
  logic                  push_valid;
  logic                  push_ready;
  logic [15:0]           push_data;
  logic                  pop_valid;
  logic                  pop_ready;
  logic [15:0]           pop_data;
  logic [LEVEL_W-1:0]    level;
  logic                  access;
  logic                  setup;
  logic                  sync_mismatch;
  logic                  capture;
  logic                  fifo_full;
  logic [LEVEL_W-1:0]    room;
  logic [LEVEL_W-1:0]    need;
  logic                  a_go;
  logic                  b_go;
  logic                  avg_equal;
  logic [15:0]           status;

  assign setup    = apb_req.psel && !apb_req.penable;
  assign access   = apb_req.psel && apb_req.penable;
  assign apb_resp.pready  = 1'b1;
  assign apb_resp.pslverr = access && !addr_hit(apb_req.paddr);
  assign apb_resp.prdata  = r_reg.prdata;
  // a read of the data word pops it at the access edge
  assign pop_ready = access && !apb_req.pwrite && (apb_req.paddr == ADDR_FIFO_DATA);

  assign fifo_full = (level == FIFO_DEPTH_L);
  assign room      = FIFO_DEPTH_L - level;
  assign period_ready = (r_reg.state == ST_IDLE);
  assign capture      = period_valid && period_ready;
  assign first_slot_active  = r_reg.cfg.first_slot_enable;
  assign second_slot_active = r_reg.cfg.second_slot_enable;

  assign sync_mismatch = ((r_reg.sync_sel == SYNC_SEL_ONE) || (r_reg.sync_sel == SYNC_SEL_TWO)) ?
                         (r_reg.sync_word != SYNC_INIT_WORD) : (r_reg.sync_word != 16'h0000);
  assign status = {r_reg.dropped, sync_mismatch, !pop_valid, fifo_full, level};

  assign avg_equal = (r_reg.avg[AVG_SECOND_LSB +: 3] == r_reg.avg[AVG_FIRST_LSB +: 3]);
  assign a_go = r_reg.cfg.first_slot_enable && (fmt_words(r_reg.cfg.first_slot_store_format) != 4'h0);
  assign b_go = r_reg.cfg.second_slot_enable && (fmt_words(r_reg.cfg.second_slot_store_format) != 4'h0) &&
                (avg_equal || (r_reg.cfg.first_slot_store_format == FMT_NONE));
  assign need = (a_go ? LEVEL_W'(fmt_words(r_reg.cfg.first_slot_store_format)) : 5'h00) +
                (b_go ? LEVEL_W'(fmt_words(r_reg.cfg.second_slot_store_format)) : 5'h00);

  always_comb begin
    r_next     = r_reg;
    push_valid = 1'b0;
    push_data  = 16'h0000;
    if (setup) begin
      if (apb_req.paddr == ADDR_SLOT_CFG) begin
        r_next.prdata = {16'h0000, r_reg.cfg};
      end else if (apb_req.paddr == ADDR_AVG_CFG) begin
        r_next.prdata = {16'h0000, r_reg.avg};
      end else if (apb_req.paddr == ADDR_SYNC_WORD) begin
        r_next.prdata = {16'h0000, r_reg.sync_word};
      end else if (apb_req.paddr == ADDR_SYNC_SEL) begin
        r_next.prdata = {30'h0000_0000, r_reg.sync_sel};
      end else if (apb_req.paddr == ADDR_STATUS) begin
        r_next.prdata = {16'h0000, status};
      end else if (apb_req.paddr == ADDR_FIFO_DATA) begin
        r_next.prdata = pop_valid ? {16'h0000, pop_data} : 32'h0000_0000;
      end else begin
        r_next.prdata = 32'h0000_0000;
      end
    end
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == ADDR_SLOT_CFG) begin
        r_next.cfg = apb_req.pwdata[15:0] & SLOT_CFG_MASK;
      end else if (apb_req.paddr == ADDR_AVG_CFG) begin
        r_next.avg = apb_req.pwdata[15:0] & AVG_CFG_MASK;
      end else if (apb_req.paddr == ADDR_SYNC_WORD) begin
        r_next.sync_word = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == ADDR_SYNC_SEL) begin
        r_next.sync_sel = apb_req.pwdata[1:0];
      end
    end
    case (r_reg.state)
      ST_IDLE: begin
        if (capture) begin
          if (r_reg.cfg.overrun_guard && (need > room)) begin
            if (r_reg.dropped != 8'hff) begin
              r_next.dropped = r_reg.dropped + 8'h01;
            end
          end else begin
            r_next.a_data = period_data.first;
            r_next.b_data = period_data.second;
            r_next.a_fmt  = r_reg.cfg.first_slot_store_format;
            r_next.b_fmt  = r_reg.cfg.second_slot_store_format;
            r_next.b_go   = b_go;
            r_next.guard  = r_reg.cfg.overrun_guard;
            r_next.idx    = 3'h0;
            if (a_go) begin
              r_next.state = ST_PUSH_A;
            end else if (b_go) begin
              r_next.state = ST_PUSH_B;
            end
          end
        end
      end
      ST_PUSH_A: begin
        push_valid = 1'b1;
        push_data = slot_word(r_reg.a_data, r_reg.a_fmt, r_reg.idx);
        if (push_ready) begin
          r_next.idx = r_reg.idx + 3'h1;
          if ({1'b0, r_reg.idx} == fmt_words(r_reg.a_fmt) - 4'h1) begin
            r_next.idx   = 3'h0;
            r_next.state = r_reg.b_go ? ST_PUSH_B : ST_IDLE;
          end
        end
      end
      ST_PUSH_B: begin
        push_valid = 1'b1;
        push_data = slot_word(r_reg.b_data, r_reg.b_fmt, r_reg.idx);
        if (push_ready) begin
          r_next.idx = r_reg.idx + 3'h1;
          if ({1'b0, r_reg.idx} == fmt_words(r_reg.b_fmt) - 4'h1) begin
            r_next.idx   = 3'h0;
            r_next.state = ST_IDLE;
          end
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // guard is latched per period so a config write mid-burst cannot tear it
  sffc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk         (clk),
    .reset_n     (reset_n),
    .in_valid    (push_valid),
    .in_ready    (push_ready),
    .in_data     (push_data),
    .in_overwrite(!r_reg.guard),
    .out_valid   (pop_valid),
    .out_ready   (pop_ready),
    .out_data    (pop_data),
    .level       (level)
  );

  property p_first_off;
    @(posedge clk) disable iff (!reset_n)
      (capture && !r_reg.cfg.first_slot_enable) |=> (r_reg.state != ST_PUSH_A);
  endproperty
  a_first_off: assert property (p_first_off) else $error("first slot pushed while disabled");

  property p_second_off;
    @(posedge clk) disable iff (!reset_n)
      (capture && !r_reg.cfg.second_slot_enable) |=> (r_reg.state != ST_PUSH_B) [*3];
  endproperty
  a_second_off: assert property (p_second_off) else $error("second slot pushed while disabled");

  property p_first_sum32_len;
    @(posedge clk) disable iff (!reset_n)
      (capture && a_go && !(r_reg.cfg.overrun_guard && (need > room)) &&
       (r_reg.cfg.first_slot_store_format == FMT_SUM32)) |=> (r_reg.state == ST_PUSH_A) [*2] ##1
       (r_reg.state != ST_PUSH_A);
  endproperty
  a_first_sum32_len: assert property (p_first_sum32_len) else $error("sum32 word count wrong");

  property p_sum16_value;
    @(posedge clk) disable iff (!reset_n)
      (r_reg.state == ST_PUSH_B && r_reg.b_fmt == FMT_SUM16) |->
        (push_data == 16'(r_reg.b_data.ch16[0] + r_reg.b_data.ch16[1] +
                          r_reg.b_data.ch16[2] + r_reg.b_data.ch16[3]));
  endproperty
  a_sum16_value: assert property (p_sum16_value) else $error("sum16 word wrong");

  property p_ch32_len;
    @(posedge clk) disable iff (!reset_n)
      (capture && a_go && !(r_reg.cfg.overrun_guard && (need > room)) &&
       (r_reg.cfg.first_slot_store_format == FMT_CH32)) |=> (r_reg.state == ST_PUSH_A) [*8] ##1
       (r_reg.state != ST_PUSH_A);
  endproperty
  a_ch32_len: assert property (p_ch32_len) else $error("ch32 needs eight words");

  property p_none_stores_nothing;
    @(posedge clk) disable iff (!reset_n)
      (capture && (fmt_words(r_reg.cfg.first_slot_store_format) == 4'h0)) |=> (r_reg.state != ST_PUSH_A);
  endproperty
  a_none_stores_nothing: assert property (p_none_stores_nothing) else $error("code 0 pushed");

  property p_avg_gate;
    @(posedge clk) disable iff (!reset_n)
      (capture && !avg_equal && (r_reg.cfg.first_slot_store_format != FMT_NONE)) |=>
        (r_reg.state != ST_PUSH_B) [*8] ##1 (r_reg.state != ST_PUSH_B);
  endproperty
  a_avg_gate: assert property (p_avg_gate) else $error("second slot stored with unequal averaging");

  property p_guard_full;
    @(posedge clk) disable iff (!reset_n)
      (push_valid && r_reg.guard && fifo_full) |-> !push_ready;
  endproperty
  a_guard_full: assert property (p_guard_full) else $error("guarded fifo written while full");

  property p_guard_drop;
    @(posedge clk) disable iff (!reset_n)
      (capture && r_reg.cfg.overrun_guard && (need > room)) |=> (r_reg.state == ST_IDLE);
  endproperty
  a_guard_drop: assert property (p_guard_drop) else $error("guarded period stored without room");

  property p_wrap_keeps_full;
    @(posedge clk) disable iff (!reset_n)
      (push_valid && !r_reg.guard && fifo_full && !pop_ready) |=> fifo_full;
  endproperty
  a_wrap_keeps_full: assert property (p_wrap_keeps_full) else $error("wrap write lost fullness");

  property p_order;
    @(posedge clk) disable iff (!reset_n)
      (r_reg.state == ST_PUSH_B) |=> (r_reg.state != ST_PUSH_A);
  endproperty
  a_order: assert property (p_order) else $error("first slot word after second slot");
endmodule
`default_nettype wire

// ### sffc_pkg.sv
`default_nettype none
package sffc_pkg;
  localparam int unsigned FIFO_WIDTH = 16;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LEVEL_W    = 5;
  localparam logic [LEVEL_W-1:0] FIFO_DEPTH_L = 5'h10;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_SLOT_CFG  = 12'h011;
  localparam logic [11:0] IDX_AVG_CFG   = 12'h015;
  localparam logic [11:0] IDX_SYNC_WORD = 12'h038;
  localparam logic [11:0] IDX_SYNC_SEL  = 12'h040;
  localparam logic [11:0] IDX_STATUS    = 12'h041;
  localparam logic [11:0] IDX_FIFO_DATA = 12'h042;
  localparam logic [11:0] ADDR_SLOT_CFG  = {IDX_SLOT_CFG[9:0], 2'b00};
  localparam logic [11:0] ADDR_AVG_CFG   = {IDX_AVG_CFG[9:0], 2'b00};
  localparam logic [11:0] ADDR_SYNC_WORD = {IDX_SYNC_WORD[9:0], 2'b00};
  localparam logic [11:0] ADDR_SYNC_SEL  = {IDX_SYNC_SEL[9:0], 2'b00};
  localparam logic [11:0] ADDR_STATUS    = {IDX_STATUS[9:0], 2'b00};
  localparam logic [11:0] ADDR_FIFO_DATA = {IDX_FIFO_DATA[9:0], 2'b00};

  localparam logic [15:0] SLOT_CFG_RST   = 16'h1000;
  localparam logic [15:0] SLOT_CFG_MASK  = 16'h31fd;
  localparam logic [15:0] AVG_CFG_RST    = 16'h0000;
  localparam logic [15:0] AVG_CFG_MASK   = 16'h0770;
  localparam logic [15:0] SYNC_WORD_RST  = 16'h0000;
  localparam logic [15:0] SYNC_INIT_WORD = 16'h4000;
  localparam logic [1:0]  SYNC_SEL_RST   = 2'h0;
  localparam logic [1:0]  SYNC_SEL_ONE   = 2'h1;
  localparam logic [1:0]  SYNC_SEL_TWO   = 2'h2;
  localparam int unsigned AVG_FIRST_LSB  = 4;
  localparam int unsigned AVG_SECOND_LSB = 8;

  localparam logic [2:0] FMT_NONE  = 3'h0;
  localparam logic [2:0] FMT_SUM16 = 3'h1;
  localparam logic [2:0] FMT_SUM32 = 3'h2;
  localparam logic [2:0] FMT_CH16  = 3'h4;
  localparam logic [2:0] FMT_CH32  = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_PUSH_A = 3'b010,
    ST_PUSH_B = 3'b100
  } sffc_state_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       readout_mode;
    logic       overrun_guard;
    logic [2:0] rsv_mid;
    logic [2:0] second_slot_store_format;
    logic       second_slot_enable;
    logic [2:0] first_slot_store_format;
    logic       rsv_lo;
    logic       first_slot_enable;
  } sffc_slot_cfg_t;

  typedef struct packed {
    logic [3:0][15:0] ch16;
    logic [3:0][31:0] ch32;
  } sffc_slot_sample_t;

  typedef struct packed {
    sffc_slot_sample_t first;
    sffc_slot_sample_t second;
  } sffc_period_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } sffc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sffc_apb_resp_t;

  function automatic logic [3:0] fmt_words(input logic [2:0] fmt);
    case (fmt)
      FMT_SUM16: fmt_words = 4'h1;
      FMT_SUM32: fmt_words = 4'h2;
      FMT_CH16:  fmt_words = 4'h4;
      FMT_CH32:  fmt_words = 4'h8;
      default:   fmt_words = 4'h0;
    endcase
  endfunction

  function automatic logic [31:0] sum32(input sffc_slot_sample_t s);
    sum32 = s.ch32[0] + s.ch32[1] + s.ch32[2] + s.ch32[3];
  endfunction

  function automatic logic [15:0] sum16(input sffc_slot_sample_t s);
    sum16 = s.ch16[0] + s.ch16[1] + s.ch16[2] + s.ch16[3];
  endfunction

  // 32-bit values go out low half first
  function automatic logic [15:0] slot_word(input sffc_slot_sample_t s, input logic [2:0] fmt,
                                            input logic [2:0] idx);
    logic [31:0] total;
    logic [31:0] wide;
    total = sum32(s);
    wide  = s.ch32[idx[2:1]];
    case (fmt)
      FMT_SUM16: slot_word = sum16(s);
      FMT_SUM32: slot_word = idx[0] ? total[31:16] : total[15:0];
      FMT_CH16:  slot_word = s.ch16[idx[1:0]];
      FMT_CH32:  slot_word = idx[0] ? wide[31:16] : wide[15:0];
      default:   slot_word = 16'h0000;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### sffc_fifo.sv
`default_nettype none
module sffc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_overwrite,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 count;
    logic [WIDTH-1:0]            out;
  } sffc_fifo_state_t;

  sffc_fifo_state_t r_reg;
  sffc_fifo_state_t r_next;
  logic full;
  logic push;
  logic pop;

  assign full      = (r_reg.count == (PW+1)'(DEPTH));
  assign in_ready  = !full || in_overwrite;
  assign out_valid = (r_reg.count != '0);
  assign out_data  = r_reg.out;
  assign level     = r_reg.count;
  assign push      = in_valid && in_ready;
  // a full write in wrap mode drops the oldest word unless the reader takes it now
  assign pop       = (out_valid && out_ready) || (push && full);

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = r_reg.wr + 1'b1;
    end
    if (pop) begin
      r_next.rd = r_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      r_next.count = r_reg.count + 1'b1;
    end else if (pop && !push) begin
      r_next.count = r_reg.count - 1'b1;
    end
    r_next.out = r_next.mem[r_next.rd];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule
`default_nettype wire

// ### sffc_slot_fifo_cfg_bench.sv
`default_nettype none
module sffc_slot_fifo_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sffc_pkg::*;

  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  sffc_apb_req_t     apb_req = '0;
  sffc_apb_resp_t    apb_resp;
  logic              period_valid = 1'b0;
  logic              period_ready;
  sffc_period_t      period_data = '0;
  logic              first_slot_active;
  logic              second_slot_active;
  int                bad_count = 0;
  int                checked = 0;
  int                cycles = 0;
  logic [15:0]       exp_q[$];
  logic [31:0]       rd;
  logic              err;
  sffc_slot_sample_t sa;
  sffc_slot_sample_t sb;
  logic [2:0]        codes[7] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h0, 3'h3, 3'h5};

  sffc_slot_fifo_cfg dut (
    .clk               (clk),
    .reset_n           (reset_n),
    .apb_req           (apb_req),
    .apb_resp          (apb_resp),
    .period_valid      (period_valid),
    .period_ready      (period_ready),
    .period_data       (period_data),
    .first_slot_active (first_slot_active),
    .second_slot_active(second_slot_active)
  );

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one transfer, then one idle cycle so the next setup never collides with the release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    apb_req.paddr <= a;
    apb_req.pwrite <= wr;
    apb_req.pwdata <= wd;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // pready high ends this wait; only the global cycle ceiling bounds it
    do begin
      @(posedge clk);
    end while (apb_resp.pready !== 1'b1);
    rd = apb_resp.prdata;
    err = apb_resp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  function automatic logic [31:0] cfg(input logic g, input logic [2:0] fb, input logic eb,
                                      input logic [2:0] fa, input logic ea);
    cfg = {16'h0, 3'h0, g, 3'h0, fb, eb, fa, 1'b0, ea};
  endfunction

  // offers one period and waits until the sequencer is idle again
  task automatic push;
    period_data <= {sa, sb};
    period_valid <= 1'b1;
    do begin
      @(posedge clk);
    end while (period_ready !== 1'b1);
    period_valid <= 1'b0;
    do begin
      @(posedge clk);
    end while (period_ready !== 1'b1);
    @(posedge clk);
  endtask

  // expected words of one slot, 32-bit values low half first
  task automatic add(input sffc_slot_sample_t s, input logic [2:0] f);
    logic [31:0] t;
    logic [15:0] h;
    t = s.ch32[0] + s.ch32[1] + s.ch32[2] + s.ch32[3];
    h = s.ch16[0] + s.ch16[1] + s.ch16[2] + s.ch16[3];
    case (f)
      3'h1: exp_q.push_back(h);
      3'h2: begin
        exp_q.push_back(t[15:0]);
        exp_q.push_back(t[31:16]);
      end
      3'h4: for (int i = 0; i < 4; i++) exp_q.push_back(s.ch16[i]);
      3'h6: for (int i = 0; i < 4; i++) begin
        exp_q.push_back(s.ch32[i][15:0]);
        exp_q.push_back(s.ch32[i][31:16]);
      end
      default: ;
    endcase
  endtask

  task automatic drain(input string nm);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("level", {27'h0, rd[4:0]}, exp_q.size());
    while (exp_q.size() > 0) begin
      apb(1'b0, ADDR_FIFO_DATA, 32'h0);
      check(nm, rd, {16'h0, exp_q.pop_front()});
    end
  endtask

  initial begin
    // sums other than the sb 16-bit sum overflow on purpose so truncation is seen
    for (int i = 0; i < 4; i++) begin
      sa.ch16[i] = 16'hc000 + 16'h0101 * 16'(i);
      sa.ch32[i] = 32'h9000_0000 + 32'h0102_0304 * 32'(i);
      sb.ch16[i] = 16'h3000 + 16'h0011 * 16'(i);
      sb.ch32[i] = 32'h7000_0000 + 32'h0a0b_0c0d * 32'(i);
    end
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("first act rst", first_slot_active, 1'b0);
    check("second act rst", second_slot_active, 1'b0);
    rchk(ADDR_SLOT_CFG, 32'h1000, "slot cfg rst");
    check("mapped err", err, 1'b0);
    rchk(ADDR_AVG_CFG, 32'h0, "avg rst");
    rchk(ADDR_SYNC_WORD, 32'h0, "sync rst");
    rchk(ADDR_STATUS, 32'h40, "status rst");
    apb(1'b0, 12'h3fc, 32'h0);
    check("unmapped rd", rd, 32'h0);
    check("unmapped err", err, 1'b1);
    apb(1'b1, ADDR_SLOT_CFG, 32'hffff_ffff);
    rchk(ADDR_SLOT_CFG, 32'h31fd, "slot cfg mask");
    check("first act", first_slot_active, 1'b1);
    check("second act", second_slot_active, 1'b1);
    push();
    drain("code seven");
    apb(1'b1, ADDR_AVG_CFG, 32'hffff_ffff);
    rchk(ADDR_AVG_CFG, 32'h0770, "avg mask");
    apb(1'b1, ADDR_AVG_CFG, 32'h0);
    apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, 3'h0, 1'b0, 3'h0, 1'b0));
    check("first off", first_slot_active, 1'b0);
    check("second off", second_slot_active, 1'b0);
    // sync word stored, mismatch only reported
    apb(1'b1, ADDR_SYNC_SEL, 32'h1);
    apb(1'b1, ADDR_SYNC_WORD, 32'hffff_4000);
    rchk(ADDR_SYNC_WORD, 32'h4000, "sync word");
    rchk(ADDR_STATUS, 32'h40, "sync ok");
    apb(1'b1, ADDR_SYNC_SEL, 32'h3);
    rchk(ADDR_STATUS, 32'hc0, "sync bad");
    apb(1'b1, ADDR_SYNC_SEL, 32'h2);
    // every code but 7 on each slot alone
    for (int s = 0; s < 2; s++) begin
      foreach (codes[k]) begin
        if (s == 0) begin
          // second slot disabled but formatted, so it must stay silent
          apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, 3'h4, 1'b0, codes[k], 1'b1));
          add(sa, codes[k]);
        end else begin
          // first slot disabled but formatted, so it must stay silent
          apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, codes[k], 1'b1, 3'h4, 1'b0));
          add(sb, codes[k]);
        end
        push();
        drain("format");
      end
    end
    // second slot gated by averaging match
    apb(1'b1, ADDR_AVG_CFG, 32'h0330);
    apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, 3'h4, 1'b1, 3'h1, 1'b1));
    push();
    add(sa, 3'h1);
    add(sb, 3'h4);
    drain("order");
    apb(1'b1, ADDR_AVG_CFG, 32'h0230);
    push();
    add(sa, 3'h1);
    drain("avg differ");
    apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, 3'h2, 1'b1, 3'h0, 1'b1));
    push();
    add(sb, 3'h2);
    drain("first none");
    // guard drops a period, then wrap overwrites oldest
    apb(1'b1, ADDR_AVG_CFG, 32'h0);
    apb(1'b1, ADDR_SLOT_CFG, cfg(1'b1, 3'h0, 1'b0, 3'h6, 1'b1));
    push();
    push();
    rchk(ADDR_STATUS, 32'h30, "full");
    push();
    rchk(ADDR_STATUS, 32'h130, "dropped");
    apb(1'b1, ADDR_SLOT_CFG, cfg(1'b0, 3'h0, 1'b0, 3'h4, 1'b1));
    push();
    add(sa, 3'h6);
    add(sa, 3'h6);
    add(sa, 3'h4);
    repeat (4) void'(exp_q.pop_front());
    drain("wrap");
    rchk(ADDR_STATUS, 32'h140, "drained");
    rchk(ADDR_FIFO_DATA, 32'h0, "empty pop");
    complete_run();
  end
endmodule
`default_nettype wire
